// [logic/ssc_correct.sv]
`timescale 1ns/1ps
`default_nettype none
module ssc_correct (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [7:0] raw_reading,
    input wire logic [7:0] correction_code,
    output logic [7:0] corrected_reading
);
    import ssc_pkg::*;

    typedef struct packed {
        logic [7:0] value;
    } ssc_corr_state_t;

    ssc_corr_state_t st_q;
    ssc_corr_state_t st_d;
    logic [9:0] sum;

    // trim is a signed offset; saturate so a large trim cannot wrap the reading
    always_comb begin
        st_d = st_q;
        sum = {2'h0, raw_reading} + {{2{correction_code[7]}}, correction_code};
        if (sum[9]) begin
            st_d.value = 8'h00;
        end else if (sum[8]) begin
            st_d.value = 8'hFF;
        end else begin
            st_d.value = sum[7:0];
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign corrected_reading = st_q.value;

    chk_trim_applied:
    assert property (@(posedge core_clk) disable iff (!rst_n)
        (correction_code == 8'h00) |=> (corrected_reading == $past(raw_reading)))
    else $error("zero trim altered the reading");
endmodule : ssc_correct
`default_nettype wire

// [logic/ssc_pkg.sv]
`default_nettype none
package ssc_pkg;
    // register map, byte offsets on the management register port
    localparam logic [7:0] SSC_OFS_CURRENT_VALUE = 8'h18;
    localparam logic [7:0] SSC_OFS_GAIN_TRIM = 8'h23;
    localparam logic [7:0] SSC_OFS_OFFSET_TRIM = 8'h24;
    localparam logic [7:0] SSC_OFS_DIGITAL_TRIM = 8'h25;

    // reset values of the three trim registers
    localparam logic [7:0] SSC_RST_GAIN_TRIM = 8'h00;
    localparam logic [7:0] SSC_RST_OFFSET_TRIM = 8'h00;
    localparam logic [7:0] SSC_RST_DIGITAL_TRIM = 8'h00;
    localparam logic [7:0] SSC_RDATA_UNMAPPED = 8'h00;

    // field positions
    localparam int SSC_RANGE_MSB = 7;
    localparam int SSC_RANGE_LSB = 6;
    localparam int SSC_GAIN_MSB = 4;
    localparam int SSC_HIGH_SIDE_BIT = 7;
    localparam int SSC_OFFSET_NEG_BIT = 6;
    localparam int SSC_OFFSET_MAG_MSB = 5;

    // range codes
    localparam logic [1:0] SSC_RANGE_37M5 = 2'h0;
    localparam logic [1:0] SSC_RANGE_75M = 2'h1;
    localparam logic [1:0] SSC_RANGE_150M = 2'h2;

    // full-scale drop in units of 0.1 mV
    localparam logic [15:0] SSC_FS_37M5 = 16'h0177;
    localparam logic [15:0] SSC_FS_75M = 16'h02EE;
    localparam logic [15:0] SSC_FS_150M = 16'h05DC;
    // converter step in units of 10 nV
    localparam logic [15:0] SSC_LSB_15U26 = 16'h05F6;
    localparam logic [15:0] SSC_LSB_30U52 = 16'h0BEC;
    localparam logic [15:0] SSC_LSB_61U04 = 16'h17D8;
    // the undefined range code reports zero for both
    localparam logic [15:0] SSC_UNDEFINED = 16'h0000;
endpackage : ssc_pkg
`default_nettype wire

// [logic/ssc_trim_regs.sv]
// What this block does
// - range field bits 7:6 picks full-scale drop 37.5, 75 or 150 mV
// - same field picks converter step 15.26, 30.52 or 61.04 uV
// - gain trim bits 4:0 is the gain code applied to the sense path
// - offset bit 6 set gives negative offset, clear gives positive
// - offset bits 5:0 are the common-mode correction magnitude
// - digital trim corrects the reading returned at offset 0x18
`timescale 1ns/1ps
`default_nettype none
module ssc_trim_regs (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic [7:0] raw_reading,
    output logic [1:0] sense_full_scale_range,
    output logic [15:0] full_scale_drop,
    output logic [15:0] lsb_weight,
    output logic [4:0] sense_gain_code,
    output logic high_side_select,
    output logic offset_negative,
    output logic [5:0] offset_magnitude_code,
    output logic [7:0] reading_correction_code,
    output logic [7:0] corrected_reading
);
    import ssc_pkg::*;

    typedef struct packed {
        logic [7:0] gain;
        logic [7:0] offs;
        logic [7:0] dtrim;
        logic [7:0] rdata;
        logic rvalid;
        logic [15:0] fs;
        logic [15:0] lsb;
    } ssc_top_state_t;

    ssc_top_state_t st_q;
    ssc_top_state_t st_d;
    logic [7:0] corrected;

    // the reading path; trim takes effect on the next sample after a write
    ssc_correct ssc_correct_i (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .raw_reading(raw_reading),
        .correction_code(st_q.dtrim),
        .corrected_reading(corrected)
    );

    // register writes, decode of the range field, registered read data
    always_comb begin
        st_d = st_q;
        if (reg_wr) begin
            case (reg_addr)
                SSC_OFS_GAIN_TRIM: st_d.gain = reg_wdata;
                SSC_OFS_OFFSET_TRIM: st_d.offs = reg_wdata;
                SSC_OFS_DIGITAL_TRIM: st_d.dtrim = reg_wdata;
                default: st_d.gain = st_q.gain;
            endcase
        end
        // decoded from the next value so tables follow a write in the same edge
        case (st_d.gain[SSC_RANGE_MSB:SSC_RANGE_LSB])
            SSC_RANGE_37M5: begin
                st_d.fs = SSC_FS_37M5;
                st_d.lsb = SSC_LSB_15U26;
            end
            SSC_RANGE_75M: begin
                st_d.fs = SSC_FS_75M;
                st_d.lsb = SSC_LSB_30U52;
            end
            SSC_RANGE_150M: begin
                st_d.fs = SSC_FS_150M;
                st_d.lsb = SSC_LSB_61U04;
            end
            default: begin
                // code 11 has no meaning; report zero rather than guess
                st_d.fs = SSC_UNDEFINED;
                st_d.lsb = SSC_UNDEFINED;
            end
        endcase
        st_d.rvalid = reg_rd;
        st_d.rdata = SSC_RDATA_UNMAPPED;
        if (reg_rd) begin
            case (reg_addr)
                SSC_OFS_CURRENT_VALUE: st_d.rdata = corrected;
                SSC_OFS_GAIN_TRIM: st_d.rdata = st_q.gain;
                SSC_OFS_OFFSET_TRIM: st_d.rdata = st_q.offs;
                SSC_OFS_DIGITAL_TRIM: st_d.rdata = st_q.dtrim;
                default: st_d.rdata = SSC_RDATA_UNMAPPED;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q.gain <= SSC_RST_GAIN_TRIM;
            st_q.offs <= SSC_RST_OFFSET_TRIM;
            st_q.dtrim <= SSC_RST_DIGITAL_TRIM;
            st_q.rdata <= SSC_RDATA_UNMAPPED;
            st_q.rvalid <= 1'b0;
            st_q.fs <= SSC_FS_37M5;
            st_q.lsb <= SSC_LSB_15U26;
        end else begin
            st_q <= st_d;
        end
    end

    // outputs are flop slices; software owns the meaning of high_side_select
    assign reg_rdata = st_q.rdata;
    assign reg_rvalid = st_q.rvalid;
    assign sense_full_scale_range = st_q.gain[SSC_RANGE_MSB:SSC_RANGE_LSB];
    assign full_scale_drop = st_q.fs;
    assign lsb_weight = st_q.lsb;
    assign sense_gain_code = st_q.gain[SSC_GAIN_MSB:0];
    assign high_side_select = st_q.offs[SSC_HIGH_SIDE_BIT];
    assign offset_negative = st_q.offs[SSC_OFFSET_NEG_BIT];
    assign offset_magnitude_code = st_q.offs[SSC_OFFSET_MAG_MSB:0];
    assign reading_correction_code = st_q.dtrim;
    assign corrected_reading = corrected;

    chk_fs_table:
    assert property (@(posedge core_clk) disable iff (!rst_n)
        (reg_wr && reg_addr == SSC_OFS_GAIN_TRIM && reg_wdata[7:6] == 2'h2)
        |=> (full_scale_drop == SSC_FS_150M) && (sense_full_scale_range == 2'h2))
    else $error("full-scale drop does not follow range code");

    chk_lsb_table:
    assert property (@(posedge core_clk) disable iff (!rst_n)
        (sense_full_scale_range == 2'h1) |-> (lsb_weight == SSC_LSB_30U52))
    else $error("step size does not follow range code");

    chk_gain_write:
    assert property (@(posedge core_clk) disable iff (!rst_n)
        (reg_wr && reg_addr == SSC_OFS_GAIN_TRIM)
        |=> (sense_gain_code == $past(reg_wdata[4:0])))
    else $error("gain code not taken from write");

    chk_offset_sign:
    assert property (@(posedge core_clk) disable iff (!rst_n)
        (reg_wr && reg_addr == SSC_OFS_OFFSET_TRIM)
        |=> (offset_negative == $past(reg_wdata[6]))
        && (high_side_select == $past(reg_wdata[7])))
    else $error("offset sign or side not taken from write");

    chk_offset_mag:
    assert property (@(posedge core_clk) disable iff (!rst_n)
        (reg_wr && reg_addr == SSC_OFS_OFFSET_TRIM) ##1 !reg_wr
        |=> (offset_magnitude_code == $past(reg_wdata[5:0], 2)))
    else $error("offset magnitude lost after write");

    chk_value_read:
    assert property (@(posedge core_clk) disable iff (!rst_n)
        (reg_rd && reg_addr == SSC_OFS_CURRENT_VALUE)
        |=> reg_rvalid && (reg_rdata == $past(corrected)))
    else $error("current value read does not return corrected reading");

    chk_trim_feeds:
    assert property (@(posedge core_clk) disable iff (!rst_n)
        (reg_wr && reg_addr == SSC_OFS_DIGITAL_TRIM)
        |=> (reading_correction_code == $past(reg_wdata)))
    else $error("digital trim not stored");

    chk_no_stray_valid:
    assert property (@(posedge core_clk) disable iff (!rst_n)
        !reg_rd |=> !reg_rvalid)
    else $error("read valid without a read");

    // table checks hold at all times, not only right after a write
    chk_low_range:
    assert property (@(posedge core_clk) disable iff (!rst_n)
        (sense_full_scale_range == 2'h0)
        |-> (full_scale_drop == SSC_FS_37M5) && (lsb_weight == SSC_LSB_15U26))
    else $error("lowest range decode wrong");

    chk_mid_range:
    assert property (@(posedge core_clk) disable iff (!rst_n)
        (sense_full_scale_range == 2'h1) |-> (full_scale_drop == SSC_FS_75M))
    else $error("middle range full-scale drop wrong");

    chk_high_range:
    assert property (@(posedge core_clk) disable iff (!rst_n)
        (sense_full_scale_range == 2'h2)
        |-> (lsb_weight == SSC_LSB_61U04) && (full_scale_drop == SSC_FS_150M))
    else $error("highest range decode wrong");

    chk_undefined_range:
    assert property (@(posedge core_clk) disable iff (!rst_n)
        (sense_full_scale_range == 2'h3)
        |-> (full_scale_drop == SSC_UNDEFINED) && (lsb_weight == SSC_UNDEFINED))
    else $error("undefined range code not reported as zero");

    // a write anywhere else, the reading offset included, must not touch a trim
    chk_unmapped_write:
    assert property (@(posedge core_clk) disable iff (!rst_n)
        (reg_wr && (reg_addr != SSC_OFS_GAIN_TRIM) && (reg_addr != SSC_OFS_OFFSET_TRIM)
        && (reg_addr != SSC_OFS_DIGITAL_TRIM))
        |=> $stable(sense_gain_code) && $stable(offset_magnitude_code)
        && $stable(reading_correction_code))
    else $error("unmapped write changed a trim");

    chk_read_answers:
    assert property (@(posedge core_clk) disable iff (!rst_n)
        reg_rd |=> reg_rvalid)
    else $error("read strobe got no answer");

    chk_gain_readback:
    assert property (@(posedge core_clk) disable iff (!rst_n)
        (reg_rd && reg_addr == SSC_OFS_GAIN_TRIM)
        |=> (reg_rdata[4:0] == $past(sense_gain_code)))
    else $error("gain trim read does not match gain code");

    chk_offset_readback:
    assert property (@(posedge core_clk) disable iff (!rst_n)
        (reg_rd && reg_addr == SSC_OFS_OFFSET_TRIM)
        |=> (reg_rdata[5:0] == $past(offset_magnitude_code))
        && (reg_rdata[6] == $past(offset_negative)))
    else $error("offset trim read does not match fields");

    // offset fields only move on a write to their own register
    chk_offset_hold:
    assert property (@(posedge core_clk) disable iff (!rst_n)
        !(reg_wr && reg_addr == SSC_OFS_OFFSET_TRIM)
        |=> $stable(high_side_select) && $stable(offset_negative)
        && $stable(offset_magnitude_code))
    else $error("offset fields changed without a write");
endmodule : ssc_trim_regs
`default_nettype wire

// [tb/ssc_trim_regs_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module ssc_trim_regs_tb;
    import ssc_pkg::*;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] raw_reading = 8'h00;
    logic [7:0] reg_rdata, rcc, corr, seed, d, r;
    logic reg_rvalid, hs, neg;
    logic [1:0] range;
    logic [15:0] fs, lsb;
    logic [4:0] gain;
    logic [5:0] mag;
    int error_cnt = 0;
    int compares = 0;

    ssc_trim_regs ssc_trim_regs_i (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .raw_reading(raw_reading), .sense_full_scale_range(range),
        .full_scale_drop(fs), .lsb_weight(lsb), .sense_gain_code(gain),
        .high_side_select(hs), .offset_negative(neg), .offset_magnitude_code(mag),
        .reading_correction_code(rcc), .corrected_reading(corr));

    // 10 MHz core clock
    always #50 core_clk = ~core_clk;

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr

    // expected decode tables; code 11 reports zero
    function automatic logic [15:0] fs_of(input logic [1:0] c);
        return c == 2'h0 ? 16'h0177 : c == 2'h1 ? 16'h02EE : c == 2'h2 ? 16'h05DC : 16'h0000;
    endfunction : fs_of
    function automatic logic [15:0] lsb_of(input logic [1:0] c);
        return c == 2'h0 ? 16'h05F6 : c == 2'h1 ? 16'h0BEC : c == 2'h2 ? 16'h17D8 : 16'h0000;
    endfunction : lsb_of

    // signed trim added to the raw reading, clipped to the byte range
    function automatic logic [7:0] corr_of(input logic [7:0] a, input logic [7:0] t);
        logic signed [9:0] s;
        s = $signed({2'h0, a}) + $signed({{2{t[7]}}, t});
        return s < 0 ? 8'h00 : s > 255 ? 8'hFF : s[7:0];
    endfunction : corr_of

    task automatic tally_and_finish;
        if (error_cnt == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish

    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge core_clk) #1;
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = v;
        @(posedge core_clk) #1;
        reg_wr = 1'b0;
    endtask : wr

    // bounded wait for the read answer
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        int n;
        n = 0;
        @(posedge core_clk) #1;
        reg_rd = 1'b1;
        reg_addr = a;
        @(posedge core_clk) #1;
        reg_rd = 1'b0;
        while (reg_rvalid !== 1'b1 && n < 4) begin
            @(posedge core_clk) #1;
            n++;
        end
        if (reg_rvalid !== 1'b1) begin
            error_cnt++;
            $display("Error at %0t: no read answer", $time);
            tally_and_finish();
        end else begin
            cmp(reg_rdata, exp);
        end
    endtask : rd

    initial begin
        repeat (20000) @(posedge core_clk);
        error_cnt++;
        $display("Error at %0t: run timed out", $time);
        tally_and_finish();
    end

    initial begin
        seed = 8'h27;
        repeat (10) @(posedge core_clk);
        #1 rst_n = 1'b1;
        cmp(fs, 16'h0177);
        cmp(lsb, 16'h05F6);
        rd(SSC_OFS_GAIN_TRIM, 8'h00);
        rd(SSC_OFS_OFFSET_TRIM, 8'h00);
        rd(SSC_OFS_DIGITAL_TRIM, 8'h00);
        // every range code; code 11 once on purpose to see the safe decode
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            d = {i[1:0], seed[5:0]};
            wr(SSC_OFS_GAIN_TRIM, d);
            cmp(range, i[1:0]);
            cmp(fs, fs_of(i[1:0]));
            cmp(lsb, lsb_of(i[1:0]));
            cmp(gain, d[4:0]);
            rd(SSC_OFS_GAIN_TRIM, d);
        end
        // random gain writes as software makes them, off the undefined code
        for (int i = 0; i < 6; i++) begin
            seed = lfsr(seed);
            d = seed[7:6] == 2'h3 ? {2'h1, seed[5:0]} : seed;
            wr(SSC_OFS_GAIN_TRIM, d);
            cmp(fs, fs_of(d[7:6]));
            cmp(lsb, lsb_of(d[7:6]));
            cmp(gain, d[4:0]);
        end
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            wr(SSC_OFS_OFFSET_TRIM, seed);
            cmp(hs, seed[7]);
            cmp(neg, seed[6]);
            cmp(mag, seed[5:0]);
            rd(SSC_OFS_OFFSET_TRIM, seed);
        end
        // two clipping corners first, then random pairs
        for (int i = 0; i < 10; i++) begin
            seed = lfsr(seed);
            r = i == 0 ? 8'hF0 : i == 1 ? 8'h05 : seed;
            seed = lfsr(seed);
            d = i == 0 ? 8'h7F : i == 1 ? 8'hF0 : seed;
            raw_reading = r;
            wr(SSC_OFS_DIGITAL_TRIM, d);
            cmp(rcc, d);
            // the reading is registered, so the new trim shows one edge later
            @(posedge core_clk) #1;
            cmp(corr, corr_of(r, d));
            rd(SSC_OFS_CURRENT_VALUE, corr_of(r, d));
        end
        // writes to the read-only and unmapped offsets leave the trims alone
        wr(SSC_OFS_CURRENT_VALUE, 8'h55);
        wr(8'h30, 8'hAA);
        rd(8'h30, 8'h00);
        rd(SSC_OFS_DIGITAL_TRIM, d);
        // a second reset mid-run clears the trims
        @(posedge core_clk) #1 rst_n = 1'b0;
        @(posedge core_clk) #1 rst_n = 1'b1;
        cmp(rcc, 8'h00);
        cmp(hs, 1'b0);
        cmp(fs, 16'h0177);
        cmp(lsb, 16'h05F6);
        cmp(corr, 8'h00);
        // first edge after release passes the raw reading with zero trim
        @(posedge core_clk) #1;
        cmp(corr, r);
        rd(SSC_OFS_GAIN_TRIM, 8'h00);
        tally_and_finish();
    end
endmodule : ssc_trim_regs_tb
`default_nettype wire
